// ==== include/warmup_pkg.sv ====
`default_nettype none

package warmup_pkg;

  // Register byte addresses on the APB window
  localparam logic [7:0] ADDR_LOWER_CTRL = 8'h00;
  localparam logic [7:0] ADDR_UPPER_CTRL = 8'h04;
  localparam logic [7:0] ADDR_PERIOD_LOWER = 8'h08;
  localparam logic [7:0] ADDR_PERIOD_UPPER = 8'h0C;
  localparam logic [7:0] ADDR_COUNT = 8'h10;

  // Timer control byte: init flop, clock select, run, mode
  typedef struct packed {
    logic init;
    logic [2:0] clk_sel;
    logic run;
    logic [2:0] mode;
  } timer_ctrl_s;

  // Clock select codes of the lower timer
  localparam logic [2:0] CLK_SEL_LOW = 3'h4;
  localparam logic [2:0] CLK_SEL_HIGH = 3'h6;

  // Mode codes: lower half of the cascade, upper half as warm-up
  localparam logic [2:0] MODE_CASCADE = 3'h3;
  localparam logic [2:0] MODE_WARMUP = 3'h5;

  // Typical set-up bytes written by software
  localparam logic [7:0] LOWER_CTRL_WARMUP = 8'h43;
  localparam logic [7:0] UPPER_CTRL_WARMUP = 8'h05;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // Period range in source clock ticks, low byte never compared
  localparam logic [7:0] MATCH_LOW_BYTE = 8'h00;
  localparam logic [15:0] PERIOD_MIN = 16'h0100;
  localparam logic [15:0] PERIOD_MAX = 16'hFF00;

  // Upper bits of a read word are zero
  localparam logic [23:0] READ_PAD = 24'h00_0000;
  localparam logic [15:0] READ_PAD16 = 16'h0000;

endpackage : warmup_pkg

`default_nettype wire

// ==== rtl/oscillator_warmup_counter.sv ====
// Operation
// - Warm-up mode chains both 8-bit timers into one 16-bit counter.
// - Only the upper period byte is compared; the lower byte plays no part.
// - Writing 1 to the upper run bit starts warm-up counting.
// - On a match the counter clears and the upper interrupt pulses together.
// - On the slow clock the period spans 0100 to FF00 ticks of that clock.
// - On the fast clock the period spans 0100 to FF00 ticks of that clock.
// - Writing 43 hex to lower control picks slow clock, flop 0, cascade.
// - Writing 05 hex to upper control picks warm-up, flop 0, run clear.
// - Reset clears the upper timer's output flop.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`default_nettype none

module oscillator_warmup_counter (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic LOW_FREQ_CLOCK,
  input wire logic HIGH_FREQ_CLOCK,
  output logic UPPER_TIMER_IRQ,
  output logic UPPER_OUTPUT_FLOP
);

  warmup_pkg::timer_ctrl_s lower_q, lower_d, upper_q, upper_d;
  logic [7:0] per_lo_q, per_lo_d, per_hi_q, per_hi_d;
  logic [15:0] count_q, count_d, count_inc;
  logic irq_q, irq_d, flop_q, flop_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic low_rise, high_rise;
  logic setup, wr_en, wr_lower, wr_upper;
  logic warm_mode, tick, counting, match;

  // Both source clocks arrive on pins and are sampled, not used as clocks
  pin_edge_sync u_low_sync (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .pin(LOW_FREQ_CLOCK),
    .rise(low_rise)
  );

  pin_edge_sync u_high_sync (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .pin(HIGH_FREQ_CLOCK),
    .rise(high_rise)
  );

  // Bus decode: read data is prepared in setup so PREADY is a flop
  always_comb begin
    setup = PSEL & ~PENABLE;
    wr_en = PSEL & PENABLE & PWRITE & pready_q;
    wr_lower = wr_en & (PADDR == warmup_pkg::ADDR_LOWER_CTRL);
    wr_upper = wr_en & (PADDR == warmup_pkg::ADDR_UPPER_CTRL);
    pready_d = setup;
    pslverr_d = 1'b0;
    prdata_d = '0;
    if (setup) begin
      if (PADDR == warmup_pkg::ADDR_LOWER_CTRL) begin
        prdata_d = {warmup_pkg::READ_PAD, lower_q};
      end else if (PADDR == warmup_pkg::ADDR_UPPER_CTRL) begin
        prdata_d = {warmup_pkg::READ_PAD, upper_q};
      end else if (PADDR == warmup_pkg::ADDR_PERIOD_LOWER) begin
        prdata_d = {warmup_pkg::READ_PAD, per_lo_q};
      end else if (PADDR == warmup_pkg::ADDR_PERIOD_UPPER) begin
        prdata_d = {warmup_pkg::READ_PAD, per_hi_q};
      end else if (PADDR == warmup_pkg::ADDR_COUNT) begin
        prdata_d = {warmup_pkg::READ_PAD16, count_q};
      end else begin
        pslverr_d = 1'b1;
      end
    end
  end

  // Control and period registers; a write lands on the access edge
  always_comb begin
    lower_d = lower_q;
    upper_d = upper_q;
    per_lo_d = per_lo_q;
    per_hi_d = per_hi_q;
    if (wr_lower) begin
      lower_d = PWDATA[7:0];
    end
    if (wr_upper) begin
      upper_d = PWDATA[7:0];
    end
    if (wr_en && PADDR == warmup_pkg::ADDR_PERIOD_LOWER) begin
      per_lo_d = PWDATA[7:0];
    end
    if (wr_en && PADDR == warmup_pkg::ADDR_PERIOD_UPPER) begin
      per_hi_d = PWDATA[7:0];
    end
  end

  // Source tick: slow or fast oscillator, chosen by the lower control
  always_comb begin
    warm_mode = (lower_q.mode == warmup_pkg::MODE_CASCADE) &&
                (upper_q.mode == warmup_pkg::MODE_WARMUP);
    if (lower_q.clk_sel == warmup_pkg::CLK_SEL_LOW) begin
      tick = low_rise;
    end else if (lower_q.clk_sel == warmup_pkg::CLK_SEL_HIGH) begin
      tick = high_rise;
    end else begin
      tick = 1'b0;
    end
    counting = upper_q.run & warm_mode & tick;
  end

  // 16-bit up-counter; only the upper period byte sets the match point
  always_comb begin
    count_inc = count_q + 16'h0001;
    match = (count_inc == {per_hi_q, warmup_pkg::MATCH_LOW_BYTE});
    count_d = count_q;
    irq_d = 1'b0;
    if (counting) begin
      if (match) begin
        count_d = warmup_pkg::COUNT_RESET;
        irq_d = 1'b1;
      end else begin
        count_d = count_inc;
      end
    end
  end

  // Output flop: preset only while stopped, never toggles in warm-up
  always_comb begin
    flop_d = flop_q;
    if (wr_upper && !upper_q.run) begin
      flop_d = PWDATA[7];
    end
  end

  // All state registers
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lower_q <= warmup_pkg::CTRL_RESET;
      upper_q <= warmup_pkg::CTRL_RESET;
      per_lo_q <= warmup_pkg::PERIOD_RESET;
      per_hi_q <= warmup_pkg::PERIOD_RESET;
      count_q <= warmup_pkg::COUNT_RESET;
      irq_q <= 1'b0;
      flop_q <= 1'b0;
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      lower_q <= lower_d;
      upper_q <= upper_d;
      per_lo_q <= per_lo_d;
      per_hi_q <= per_hi_d;
      count_q <= count_d;
      irq_q <= irq_d;
      flop_q <= flop_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign UPPER_TIMER_IRQ = irq_q;
  assign UPPER_OUTPUT_FLOP = flop_q;

  // A counting tick advances the count by one or clears it on match
  property p_cascade_step;
    @(posedge CORE_CLK) disable iff (!RST_N)
    counting |=> (count_q == $past(count_q) + 16'h0001) ||
      (count_q == 16'h0000);
  endproperty
  a_cascade_step: assert property (p_cascade_step)
    else $error("count step wrong");

  // Interrupt fires exactly when the upper byte is reached, low byte zero
  property p_upper_only;
    @(posedge CORE_CLK) disable iff (!RST_N)
    irq_q |-> ($past(count_q) + 16'h0001) == {$past(per_hi_q), 8'h00};
  endproperty
  a_upper_only: assert property (p_upper_only)
    else $error("match point wrong");

  // Writing the run bit starts the timer
  property p_start;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (wr_upper && PWDATA[3]) |=> upper_q.run;
  endproperty
  a_start: assert property (p_start)
    else $error("run bit not set");

  // Interrupt and counter clear come in the same cycle
  property p_match_clear;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (counting && match) |=> irq_q && count_q == 16'h0000 ##1 !irq_q;
  endproperty
  a_match_clear: assert property (p_match_clear)
    else $error("match not cleared");

  // Watch the count itself, so a wrong tick mux cannot hide behind counting
  property p_slow_source;
    @(posedge CORE_CLK) disable iff (!RST_N)
    ($changed(count_q) &&
     $past(lower_q.clk_sel) == warmup_pkg::CLK_SEL_LOW) |->
      $past(low_rise) && $past(upper_q.run);
  endproperty
  a_slow_source: assert property (p_slow_source)
    else $error("slow tick wrong");

  // On the fast select the count moves only after a fast clock edge
  property p_fast_source;
    @(posedge CORE_CLK) disable iff (!RST_N)
    ($changed(count_q) &&
     $past(lower_q.clk_sel) == warmup_pkg::CLK_SEL_HIGH) |->
      $past(high_rise) && $past(upper_q.run);
  endproperty
  a_fast_source: assert property (p_fast_source)
    else $error("fast tick wrong");

  // The lower set-up byte yields slow clock, cascade, flop clear
  property p_lower_setup;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (wr_lower && PWDATA[7:0] == warmup_pkg::LOWER_CTRL_WARMUP) |=>
      lower_q.clk_sel == warmup_pkg::CLK_SEL_LOW &&
      lower_q.mode == warmup_pkg::MODE_CASCADE && !lower_q.init;
  endproperty
  a_lower_setup: assert property (p_lower_setup)
    else $error("lower setup wrong");

  // The upper set-up byte yields warm-up mode with run clear
  property p_upper_setup;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (wr_upper && PWDATA[7:0] == warmup_pkg::UPPER_CTRL_WARMUP) |=>
      upper_q.mode == warmup_pkg::MODE_WARMUP && !upper_q.run &&
      !upper_q.init;
  endproperty
  a_upper_setup: assert property (p_upper_setup)
    else $error("upper setup wrong");

  // Output flop moves only on a write to the stopped upper control
  property p_flop_hold;
    @(posedge CORE_CLK) disable iff (!RST_N)
    $changed(UPPER_OUTPUT_FLOP) |-> $past(wr_upper) && !$past(upper_q.run);
  endproperty
  a_flop_hold: assert property (p_flop_hold)
    else $error("output flop moved");

  // Stopped two cycles in a row: count unchanged and no interrupt in the second cycle
  property p_stopped_hold;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (!upper_q.run ##1 !upper_q.run) |-> $stable(count_q) && !irq_q;
  endproperty
  a_stopped_hold: assert property (p_stopped_hold)
    else $error("counted while stopped");

endmodule : oscillator_warmup_counter

`default_nettype wire

// ==== rtl/pin_edge_sync.sv ====
`default_nettype none

module pin_edge_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic rise
);

  logic s1_q, s2_q, s3_q, level_q, rise_q;
  logic level_d, rise_d;

  // Level only moves once the second and third stages agree
  always_comb begin
    level_d = (s2_q == s3_q) ? s3_q : level_q;
    rise_d = level_d & ~level_q;
  end

  // Three-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
      rise_q <= rise_d;
    end
  end

  assign rise = rise_q;

endmodule : pin_edge_sync

`default_nettype wire

// ==== verif/tb.sv ====
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic rst_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, irq, oflop;
  logic slow_pin = 0;
  logic fast_pin = 0;
  logic gen_on = 0;
  logic gen_fast = 0;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  int div = 0;
  int edges = 0;
  int irq_cnt = 0;
  logic [31:0] seed = 32'd18475;
  logic [31:0] rd;
  logic err;

  oscillator_warmup_counter oscillator_warmup_counter_i (
    .CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .LOW_FREQ_CLOCK(slow_pin),
    .HIGH_FREQ_CLOCK(fast_pin), .UPPER_TIMER_IRQ(irq),
    .UPPER_OUTPUT_FLOP(oflop)
  );

  // 25 MHz core clock
  always #20 clk = ~clk;

  // Oscillator pin, rising edge every 10 cycles so the synchroniser keeps up
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    div <= (div == 4) ? 0 : div + 1;
    if (gen_on && div == 4) begin
      if (gen_fast) fast_pin <= ~fast_pin;
      else slow_pin <= ~slow_pin;
      if ((gen_fast ? fast_pin : slow_pin) == 1'b0) edges <= edges + 1;
    end
    if (cyc == 40000) begin
      n_mismatch++;
      final_report();
    end
  end

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; holds the request until PREADY is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the global cycle ceiling may end this wait
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // Full warm-up: set up, start, wait for the match, then stop
  task automatic warm(input logic fast, input logic [7:0] up);
    seed = xorshift(seed);
    apb(1, warmup_pkg::ADDR_LOWER_CTRL, fast ?
        {24'h00_0000, 1'b0, warmup_pkg::CLK_SEL_HIGH, 1'b0,
         warmup_pkg::MODE_CASCADE} :
        {24'h00_0000, warmup_pkg::LOWER_CTRL_WARMUP});
    apb(1, warmup_pkg::ADDR_UPPER_CTRL, 32'h0000_0005);
    apb(1, warmup_pkg::ADDR_PERIOD_LOWER, {24'h00_0000, seed[7:0]});
    apb(1, warmup_pkg::ADDR_PERIOD_UPPER, {24'h00_0000, up});
    apb(0, warmup_pkg::ADDR_PERIOD_LOWER, 32'h0000_0000);
    chk(rd, {24'h00_0000, seed[7:0]});
    apb(0, warmup_pkg::ADDR_UPPER_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0005);
    edges = 0;
    gen_fast = fast;
    apb(1, warmup_pkg::ADDR_UPPER_CTRL, 32'h0000_000D);
    gen_on <= 1'b1;
    while (irq !== 1'b1) begin
      @(posedge clk);
    end
    gen_on <= 1'b0;
    chk(edges, {16'h0000, up, 8'h00});
    apb(0, warmup_pkg::ADDR_COUNT, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1, warmup_pkg::ADDR_UPPER_CTRL, 32'h0000_0005);
  endtask : warm

  task automatic final_report();
    $display("mismatches=%0d tests=%0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  initial begin
    int irq0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(oflop, 1'b0);
    // Reset values of every register, then an unmapped place
    for (int i = 0; i < 5; i++) begin
      apb(0, 8'(4 * i), 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      chk(err, 1'b0);
    end
    apb(1, 8'h14, 32'h0000_00FF);
    chk(err, 1'b1);
    apb(0, 8'h14, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(err, 1'b1);
    // Output flop follows its init bit while the timer is stopped
    apb(1, warmup_pkg::ADDR_UPPER_CTRL, 32'h0000_0080);
    chk(oflop, 1'b1);
    apb(1, warmup_pkg::ADDR_UPPER_CTRL, 32'h0000_0000);
    chk(oflop, 1'b0);
    apb(1, warmup_pkg::ADDR_LOWER_CTRL, 32'h0000_0043);
    apb(0, warmup_pkg::ADDR_LOWER_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0043);
    seed = xorshift(seed);
    warm(1'b0, 8'h01 + {7'h00, seed[0]});
    // Stopped, then running outside warm-up mode: ticks must not count
    irq0 = irq_cnt;
    for (int m = 0; m < 2; m++) begin
      apb(1, warmup_pkg::ADDR_UPPER_CTRL, m ? 32'h0000_0008 : 32'h0000_0005);
      gen_on <= 1'b1;
      repeat (60) @(posedge clk);
      gen_on <= 1'b0;
      repeat (10) @(posedge clk);
      apb(0, warmup_pkg::ADDR_COUNT, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      chk(irq_cnt, irq0);
    end
    seed = xorshift(seed);
    warm(1'b1, 8'h01 + {7'h00, seed[1]});
    chk(irq_cnt, irq0 + 1);
    chk(oflop, 1'b0);
    final_report();
  end
endmodule : tb

`default_nettype wire
